// File: common/cbbc_regs.vh
`ifndef CBBC_REGS_VH
`define CBBC_REGS_VH
`define CBBC_OFF_INTERRUPT_LINE_REPORT      8'h3D
`define CBBC_OFF_BRCTL_LO    8'h3E
`define CBBC_OFF_BRCTL_HI    8'h3F
`define CBBC_BRCTL_RESET     16'h0340
`define CBBC_BRCTL_WMASK     16'h07EF
`define CBBC_BIT_POST        10
`define CBBC_BIT_PF1         9
`define CBBC_BIT_PF0         8
`define CBBC_BIT_ROUTE       7
`define CBBC_BIT_CARD_RESET_DRIVE        6
`define CBBC_BIT_MABT        5
`define CBBC_BIT_VGA         3
`define CBBC_BIT_ISA         2
`define CBBC_BIT_CSERR       1
`define CBBC_BIT_CPERR       0
`define CBBC_SYS_BIT_TIEB    29
`define CBBC_SYS_BIT_MERGE_ALL_IRQ_LINES  28
`define CBBC_SC_SEL_HI       6
`define CBBC_SC_SEL_LO       5
`define CBBC_PIN_INTA        8'h01
`define CBBC_PIN_INTC        8'h03
`define CBBC_FUNC_CARDBUS    3'h0
`define CBBC_FUNC_FIREWIRE   3'h2
`define CBBC_FUNC_SMARTCARD  3'h5
`define CBBC_ISA_BLOCK_MASK  10'h300
`endif

// File: core/cbbc_interrupt_line_report.v
`timescale 1ns/1ps
`include "cbbc_regs.vh"
module cbbc_interrupt_line_report
(
  func_num,
  merge_all_irq_lines,
  sc_int_sel,
  interrupt_line_report
);
  input  wire [2:0] func_num;
  input  wire       merge_all_irq_lines;
  input  wire [1:0] sc_int_sel;
  output reg  [7:0] interrupt_line_report;

  always @*
  begin
    interrupt_line_report = 8'h00;
    case (func_num)
      `CBBC_FUNC_CARDBUS:
        interrupt_line_report = `CBBC_PIN_INTA;
      `CBBC_FUNC_FIREWIRE:
        interrupt_line_report = merge_all_irq_lines ? `CBBC_PIN_INTA
                                                    : `CBBC_PIN_INTC;
      `CBBC_FUNC_SMARTCARD:
        interrupt_line_report = merge_all_irq_lines ? `CBBC_PIN_INTA
                                                    : {6'h00, sc_int_sel};
      default:
        interrupt_line_report = 8'h00;
    endcase
  end
endmodule // cbbc_interrupt_line_report

// File: core/cbbc_top.v
// How it works
// - per-function interrupt pin defaults 01h/03h/02h
// - merge bit joins line B onto A
// - merge-all bit joins lines A to D
// - pin value follows merge-all tying
// - smart-card pin from its select field
// - interrupt pin register is read-only
// - reserved control bits read zero
// - bit 10 enables burst write posting
// - bit 9 window one prefetchable, reset 1
// - bit 8 window zero prefetchable, reset 1
// - bit 7 routes card interrupts
// - bit 6 drives card reset, reset 1
// - host bus reset also asserts card reset
// - only global reset sets reset bit back to 1
// - other bits back to default on host bus reset unless power-event enable
// - bit 5 reports card master aborts
// - bit 3 forwards video addresses
// - bit 2 filters upper ISA I/O blocks
// - bit 1 forwards card system error
// - bit 0 reports card parity errors
`timescale 1ns/1ps
`include "cbbc_regs.vh"
module cbbc_top
(
  clock,
  rst,
  host_bus_reset_pin,
  pme_enable,
  cfg_func,
  cfg_addr,
  cfg_wr,
  cfg_rd,
  cfg_wdata,
  cfg_rdata,
  sys_control,
  sc_general_control,
  irq_a_in,
  irq_b_in,
  irq_c_in,
  irq_d_in,
  card_irq_in,
  io_addr,
  vga_addr_hit,
  card_master_abort,
  card_serr_in,
  card_parity_err,
  irq_a_out,
  irq_b_out,
  irq_c_out,
  irq_d_out,
  card_irq_to_legacy,
  card_reset_drive,
  burst_write_buffering,
  window_one_prefetchable,
  window_zero_prefetchable,
  forward_video,
  forward_io,
  host_target_abort,
  host_serr,
  card_parity_flag
);
  input  wire        clock;
  input  wire        rst;
  input  wire        host_bus_reset_pin;
  input  wire        pme_enable;
  input  wire [2:0]  cfg_func;
  input  wire [7:0]  cfg_addr;
  input  wire        cfg_wr;
  input  wire        cfg_rd;
  input  wire [7:0]  cfg_wdata;
  output reg  [7:0]  cfg_rdata;
  input  wire [31:0] sys_control;
  input  wire [7:0]  sc_general_control;
  input  wire        irq_a_in;
  input  wire        irq_b_in;
  input  wire        irq_c_in;
  input  wire        irq_d_in;
  input  wire        card_irq_in;
  input  wire [15:0] io_addr;
  input  wire        vga_addr_hit;
  input  wire        card_master_abort;
  input  wire        card_serr_in;
  input  wire        card_parity_err;
  output reg         irq_a_out;
  output reg         irq_b_out;
  output reg         irq_c_out;
  output reg         irq_d_out;
  output reg         card_irq_to_legacy;
  output reg         card_reset_drive;
  output reg         burst_write_buffering;
  output reg         window_one_prefetchable;
  output reg         window_zero_prefetchable;
  output reg         forward_video;
  output reg         forward_io;
  output reg         host_target_abort;
  output reg         host_serr;
  output reg         card_parity_flag;

  // rst is the global reset; context bit 6 survives host bus reset
  reg  [15:0] bridging_control_reg;
  reg  [15:0] bridging_control_next;
  wire [15:0] bridging_control;
  wire [7:0]  interrupt_line_report;
  wire        merge_all_irq_lines;
  wire        merge_b_onto_a;
  wire        is_func0;
  wire        card_irq_pci;
  wire        any_merged;
  wire        isa_upper;
  wire        pin_rd_hit;
  wire        ctl_lo_wr_hit;
  wire        ctl_hi_wr_hit;
  wire        ctl_lo_rd_hit;
  wire        ctl_hi_rd_hit;
  reg  [7:0]  cfg_rdata_next;
  reg         irq_a_next;
  reg         irq_b_next;
  reg         irq_c_next;
  reg         irq_d_next;
  reg         card_irq_to_legacy_next;
  reg         card_reset_drive_next;
  reg         forward_video_next;
  reg         forward_io_next;
  reg         host_target_abort_next;
  reg         host_serr_next;
  reg         card_parity_flag_next;

  // output flops reset to what the register itself resets to
  localparam [15:0] ctl_default = `CBBC_BRCTL_RESET;

  assign merge_all_irq_lines = sys_control[`CBBC_SYS_BIT_MERGE_ALL_IRQ_LINES];
  assign merge_b_onto_a      = sys_control[`CBBC_SYS_BIT_TIEB];
  assign is_func0            = (cfg_func == `CBBC_FUNC_CARDBUS);
  assign bridging_control    = bridging_control_reg & `CBBC_BRCTL_WMASK;
  assign card_irq_pci        = card_irq_in & ~bridging_control[`CBBC_BIT_ROUTE];
  assign any_merged          = irq_a_in | irq_b_in | irq_c_in | irq_d_in | card_irq_pci;
  // upper three quarters of each 1K block: address bits 9:8 nonzero
  assign isa_upper           = |(io_addr[9:0] & `CBBC_ISA_BLOCK_MASK);

  cbbc_interrupt_line_report u_interrupt_line_report
  (
    .func_num              (cfg_func),
    .merge_all_irq_lines   (merge_all_irq_lines),
    .sc_int_sel            (sc_general_control[`CBBC_SC_SEL_HI:`CBBC_SC_SEL_LO]),
    .interrupt_line_report (interrupt_line_report)
  );

  // one decode serves reads and writes, so the two paths cannot disagree
  function cbbc_cfg_hit;
    input       strobe;
    input       func_ok;
    input [7:0] addr;
    input [7:0] target;
    begin
      cbbc_cfg_hit = strobe && func_ok && (addr == target);
    end
  endfunction

  function [15:0] cbbc_merge_byte;
    input [15:0] cur;
    input [7:0]  data;
    input        hi;
    begin
      if (hi)
        cbbc_merge_byte = {data, cur[7:0]};
      else
        cbbc_merge_byte = {cur[15:8], data};
    end
  endfunction

  assign pin_rd_hit    = cbbc_cfg_hit(cfg_rd, 1'b1, cfg_addr, `CBBC_OFF_INTERRUPT_LINE_REPORT);
  assign ctl_lo_wr_hit = cbbc_cfg_hit(cfg_wr, is_func0, cfg_addr, `CBBC_OFF_BRCTL_LO);
  assign ctl_hi_wr_hit = cbbc_cfg_hit(cfg_wr, is_func0, cfg_addr, `CBBC_OFF_BRCTL_HI);
  assign ctl_lo_rd_hit = cbbc_cfg_hit(cfg_rd, is_func0, cfg_addr, `CBBC_OFF_BRCTL_LO);
  assign ctl_hi_rd_hit = cbbc_cfg_hit(cfg_rd, is_func0, cfg_addr, `CBBC_OFF_BRCTL_HI);

  always @*
  begin
    bridging_control_next = bridging_control_reg;
    if (ctl_lo_wr_hit)
      bridging_control_next = cbbc_merge_byte(bridging_control_reg, cfg_wdata, 1'b0)
                              & `CBBC_BRCTL_WMASK;
    else if (ctl_hi_wr_hit)
      bridging_control_next = cbbc_merge_byte(bridging_control_reg, cfg_wdata, 1'b1)
                              & `CBBC_BRCTL_WMASK;
    // writes at the pin offset have no target at all
    if (host_bus_reset_pin && !pme_enable)
    begin
      // context bit is the only one held; others return to default
      bridging_control_next = (`CBBC_BRCTL_RESET & ~(16'h0001 << `CBBC_BIT_CARD_RESET_DRIVE))
                              | (bridging_control_reg & (16'h0001 << `CBBC_BIT_CARD_RESET_DRIVE));
    end
    else if (host_bus_reset_pin)
      bridging_control_next = bridging_control_reg;
  end

  always @(posedge clock)
  begin
    if (rst)
      bridging_control_reg <= `CBBC_BRCTL_RESET;
    else
      bridging_control_reg <= bridging_control_next;
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      cfg_rdata <= 8'h00;
      irq_a_out <= 1'b0;
      irq_b_out <= 1'b0;
      irq_c_out <= 1'b0;
      irq_d_out <= 1'b0;
    end
    else
    begin
      cfg_rdata <= cfg_rdata_next;
      irq_a_out <= irq_a_next;
      irq_b_out <= irq_b_next;
      irq_c_out <= irq_c_next;
      irq_d_out <= irq_d_next;
    end
  end

  // mirrors of the stored control bits; card reset also follows the host bus reset
  always @(posedge clock)
  begin
    if (rst)
    begin
      card_reset_drive         <= ctl_default[`CBBC_BIT_CARD_RESET_DRIVE];
      burst_write_buffering    <= ctl_default[`CBBC_BIT_POST];
      window_one_prefetchable  <= ctl_default[`CBBC_BIT_PF1];
      window_zero_prefetchable <= ctl_default[`CBBC_BIT_PF0];
    end
    else
    begin
      card_reset_drive         <= card_reset_drive_next;
      burst_write_buffering    <= bridging_control[`CBBC_BIT_POST];
      window_one_prefetchable  <= bridging_control[`CBBC_BIT_PF1];
      window_zero_prefetchable <= bridging_control[`CBBC_BIT_PF0];
    end
  end

  // event paths, each gated by its enable bit; host_serr is gated by bit 1 for system errors and bit 5 for master aborts
  always @(posedge clock)
  begin
    if (rst)
    begin
      card_irq_to_legacy <= 1'b0;
      forward_video      <= 1'b0;
      forward_io         <= ~ctl_default[`CBBC_BIT_ISA];
      host_target_abort  <= 1'b0;
      host_serr          <= 1'b0;
      card_parity_flag   <= 1'b0;
    end
    else
    begin
      card_irq_to_legacy <= card_irq_to_legacy_next;
      forward_video      <= forward_video_next;
      forward_io         <= forward_io_next;
      host_target_abort  <= host_target_abort_next;
      host_serr          <= host_serr_next;
      card_parity_flag   <= card_parity_flag_next;
    end
  end

  always @*
  begin
    cfg_rdata_next = 8'h00;
    if (pin_rd_hit)
      cfg_rdata_next = interrupt_line_report;
    else if (ctl_lo_rd_hit)
      cfg_rdata_next = bridging_control[7:0];
    else if (ctl_hi_rd_hit)
      cfg_rdata_next = bridging_control[15:8];
  end

  // merged lines stay quiet so the host never sees one event twice
  always @*
  begin
    irq_a_next = irq_a_in | card_irq_pci | (merge_b_onto_a & irq_b_in);
    irq_b_next = irq_b_in & ~merge_b_onto_a;
    irq_c_next = irq_c_in;
    irq_d_next = irq_d_in;
    if (merge_all_irq_lines)
    begin
      irq_a_next = any_merged;
      irq_b_next = 1'b0;
      irq_c_next = 1'b0;
      irq_d_next = 1'b0;
    end
  end

  always @*
  begin
    card_irq_to_legacy_next = card_irq_in & bridging_control[`CBBC_BIT_ROUTE];
    card_reset_drive_next = bridging_control[`CBBC_BIT_CARD_RESET_DRIVE]
                            | host_bus_reset_pin;
    forward_video_next = vga_addr_hit & bridging_control[`CBBC_BIT_VGA];
    forward_io_next = ~(bridging_control[`CBBC_BIT_ISA] & isa_upper);
    host_target_abort_next = card_master_abort & bridging_control[`CBBC_BIT_MABT];
    host_serr_next = (card_serr_in & bridging_control[`CBBC_BIT_CSERR])
                     | (card_master_abort & bridging_control[`CBBC_BIT_MABT]);
    card_parity_flag_next = card_parity_err & bridging_control[`CBBC_BIT_CPERR];
  end
endmodule // cbbc_top

// File: tb/cbbc_card_model.sv
`timescale 1ns/1ps
module cbbc_card_model
(
  input  wire       card_reset_drive,
  input  wire [3:0] card_ev,
  output wire       card_irq_in,
  output wire       card_serr_in,
  output wire       card_parity_err,
  output wire       card_master_abort
);
  // a card held in reset signals nothing, so the bench cannot fake events then
  assign {card_irq_in, card_serr_in, card_parity_err, card_master_abort} =
    card_reset_drive ? 4'h0 : card_ev;
endmodule // cbbc_card_model

// File: tb/cbbc_top_monitor.sv
`timescale 1ns/1ps
module cbbc_top_monitor
(
  input wire        clock,
  input wire        rst,
  input wire        host_bus_reset_pin,
  input wire [2:0]  cfg_func,
  input wire [7:0]  cfg_addr,
  input wire        cfg_rd,
  input wire [7:0]  cfg_rdata,
  input wire [31:0] sys_control,
  input wire [7:0]  sc_general_control,
  input wire        irq_b_in,
  input wire        irq_c_in,
  input wire        irq_a_out,
  input wire        card_reset_drive,
  input wire        window_one_prefetchable,
  input wire        window_zero_prefetchable
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire pin_rd = cfg_rd && cfg_addr == 8'h3D;
  wire ctl_rd = cfg_rd && cfg_func == 3'h0;
  chk_pin_func0:
    assert property (pin_rd && cfg_func == 3'h0 |=> cfg_rdata == 8'h01) else $error("pin f0");
  chk_pin_func2:
    assert property (pin_rd && cfg_func == 3'h2 && !sys_control[28] |=> cfg_rdata == 8'h03)
      else $error("pin f2");
  chk_pin_merged:
    assert property (pin_rd && cfg_func == 3'h5 && sys_control[28] |=> cfg_rdata == 8'h01)
      else $error("pin f5 merged");
  chk_pin_select:
    assert property (pin_rd && cfg_func == 3'h5 && !sys_control[28]
      |=> cfg_rdata == {6'h00, $past(sc_general_control[6:5])}) else $error("pin f5 select");
  chk_reserved_field_high:
    assert property (ctl_rd && cfg_addr == 8'h3F |=> cfg_rdata[7:3] == 5'h00)
      else $error("reserved high bits");
  chk_reserved_field_low:
    assert property (ctl_rd && cfg_addr == 8'h3E |=> !cfg_rdata[4]) else $error("reserved bit");
  chk_host_reset:
    assert property (host_bus_reset_pin |=> card_reset_drive) else $error("card reset missing");
  chk_reset_vals:
    assert property ($fell(rst) |-> card_reset_drive && window_one_prefetchable
      && window_zero_prefetchable) else $error("reset outputs");
  chk_merge_b:
    assert property (sys_control[29] && irq_b_in |=> irq_a_out) else $error("line b merge");
  chk_merge_all:
    assert property (sys_control[28] && irq_c_in |=> irq_a_out) else $error("merge all");
  cover property (pin_rd);
  cover property (host_bus_reset_pin);
  cover property (sys_control[28] && irq_c_in);
endmodule // cbbc_top_monitor
bind cbbc_top cbbc_top_monitor u_mon (.clock, .rst, .host_bus_reset_pin, .cfg_func, .cfg_addr,
  .cfg_rd, .cfg_rdata, .sys_control, .sc_general_control, .irq_b_in, .irq_c_in, .irq_a_out,
  .card_reset_drive, .window_one_prefetchable, .window_zero_prefetchable);

// File: tb/tb_cbbc_top.sv
`timescale 1ns/1ps
module tb_cbbc_top;
  logic        clock = 0, rst = 1, host_bus_reset_pin = 0, pme_enable = 0;
  logic        cfg_wr = 0, cfg_rd = 0, vga_addr_hit = 0;
  logic [2:0]  cfg_func = 0;
  logic [7:0]  cfg_addr = 0, cfg_wdata = 0, sc_general_control = 8'h40;
  logic [31:0] sys_control = 0;
  logic [3:0]  irq_in = 0, card_ev = 0;
  logic [15:0] io_addr = 0;
  wire  [7:0]  cfg_rdata;
  wire irq_a_out, irq_b_out, irq_c_out, irq_d_out, card_irq_to_legacy, card_reset_drive;
  wire burst_write_buffering, window_one_prefetchable, window_zero_prefetchable;
  wire forward_video, forward_io, host_target_abort, host_serr, card_parity_flag;
  wire card_irq_in, card_serr_in, card_parity_err, card_master_abort;
  int  err_count = 0, num_checks = 0, i;
  always #2.5 clock = ~clock;
  cbbc_card_model card (.card_reset_drive, .card_ev, .card_irq_in, .card_serr_in,
    .card_parity_err, .card_master_abort);
  cbbc_top dut (.clock, .rst, .host_bus_reset_pin, .pme_enable, .cfg_func, .cfg_addr, .cfg_wr,
    .cfg_rd, .cfg_wdata, .cfg_rdata, .sys_control, .sc_general_control, .irq_a_in(irq_in[0]),
    .irq_b_in(irq_in[1]), .irq_c_in(irq_in[2]), .irq_d_in(irq_in[3]), .card_irq_in, .io_addr,
    .vga_addr_hit, .card_master_abort, .card_serr_in, .card_parity_err, .irq_a_out, .irq_b_out,
    .irq_c_out, .irq_d_out, .card_irq_to_legacy, .card_reset_drive, .burst_write_buffering,
    .window_one_prefetchable, .window_zero_prefetchable, .forward_video, .forward_io,
    .host_target_abort, .host_serr, .card_parity_flag);
  task results;
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task check(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task settle;
    repeat (2) @(negedge clock);
  endtask
  task wr(input logic [2:0] f, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {cfg_func, cfg_addr, cfg_wdata, cfg_wr} = {f, a, d, 1'b1};
    @(negedge clock);
    cfg_wr = 0;
  endtask
  task rd(input logic [2:0] f, input logic [7:0] a, input logic [7:0] e);
    @(negedge clock);
    {cfg_func, cfg_addr, cfg_rd} = {f, a, 1'b1};
    @(negedge clock);
    cfg_rd = 0;
    check("cfg_rdata", cfg_rdata, e);
  endtask
  initial
  begin
    #20000;
    err_count++;
    results;
  end
  initial
  begin
    repeat (8) @(negedge clock);
    rst = 0;
    rd(0, 8'h3E, 8'h40);
    rd(0, 8'h3F, 8'h03);
    check("reset outs", {card_reset_drive, window_one_prefetchable, window_zero_prefetchable,
      burst_write_buffering, forward_io}, 5'h1D);
    for (i = 0; i < 3; i++)
    begin
      sys_control = {2'b00, i == 1, i == 2, 28'h0};
      rd(0, 8'h3D, 8'h01);
      rd(2, 8'h3D, i == 2 ? 8'h01 : 8'h03);
      rd(5, 8'h3D, i == 2 ? 8'h01 : 8'h02);
    end
    wr(0, 8'h3D, 8'hFF);
    rd(0, 8'h3D, 8'h01);
    wr(0, 8'h3E, 8'hFF);
    wr(0, 8'h3F, 8'hFF);
    rd(0, 8'h3E, 8'hEF);
    rd(0, 8'h3F, 8'h07);
    check("window outs", {burst_write_buffering, window_one_prefetchable,
      window_zero_prefetchable}, 3'h7);
    {card_ev, vga_addr_hit, io_addr} = {4'hF, 1'b1, 16'h0100};
    wr(0, 8'h3E, 8'hAF);
    settle;
    check("events on", {card_irq_to_legacy, host_target_abort, host_serr, card_parity_flag,
      forward_video, forward_io, card_reset_drive}, 7'h7C);
    wr(0, 8'h3E, 8'h00);
    wr(0, 8'h3F, 8'h00);
    settle;
    check("events off", {card_irq_to_legacy, host_target_abort, host_serr, card_parity_flag,
      forward_video, forward_io, irq_a_out}, 7'h03);
    {card_ev, sys_control, irq_in} = {4'h0, 32'h0000_0000, 4'hE};
    settle;
    check("no merge", {irq_a_out, irq_b_out, irq_c_out, irq_d_out}, 4'h7);
    {sys_control, irq_in} = {32'h2000_0000, 4'h2};
    settle;
    check("merge b", {irq_a_out, irq_b_out, irq_c_out, irq_d_out}, 4'h8);
    {sys_control, irq_in} = {32'h1000_0000, 4'hC};
    settle;
    check("merge all", {irq_a_out, irq_b_out, irq_c_out, irq_d_out}, 4'h8);
    irq_in = 0;
    host_bus_reset_pin = 1;
    settle;
    check("card reset", card_reset_drive, 1'b1);
    host_bus_reset_pin = 0;
    rd(0, 8'h3E, 8'h00);
    rd(0, 8'h3F, 8'h03);
    pme_enable = 1;
    wr(0, 8'h3F, 8'h00);
    host_bus_reset_pin = 1;
    settle;
    host_bus_reset_pin = 0;
    pme_enable = 0;
    rd(0, 8'h3F, 8'h00);
    wr(2, 8'h3E, 8'hFF);
    rd(0, 8'h3E, 8'h00);
    rst = 1;
    settle;
    rst = 0;
    rd(0, 8'h3E, 8'h40);
    results;
  end
endmodule // tb_cbbc_top
